/* File: rtl/plsc_pkg.sv */
// package: register map, field positions, reset values and carrier types
`default_nettype none
package plsc_pkg;
    localparam int PLSC_NUM_REGS = 15;
    localparam int PLSC_IDX_SPACE0_RANGE = 0;
    localparam int PLSC_IDX_SPACE0_REMAP = 1;
    localparam int PLSC_IDX_MODE_ARB = 2;
    localparam int PLSC_IDX_ENDIAN = 3;
    localparam int PLSC_IDX_EXPROM_RANGE = 4;
    localparam int PLSC_IDX_EXPROM_REMAP = 5;
    localparam int PLSC_IDX_SPACE0_DESC = 6;
    localparam int PLSC_IDX_DM_RANGE = 7;
    localparam int PLSC_IDX_DM_MEM_BASE = 8;
    localparam int PLSC_IDX_DM_IO_BASE = 9;
    localparam int PLSC_IDX_DM_PCI_REMAP = 10;
    localparam int PLSC_IDX_DM_CFG_ADDR = 11;
    localparam int PLSC_IDX_SPACE1_RANGE = 12;
    localparam int PLSC_IDX_SPACE1_REMAP = 13;
    localparam int PLSC_IDX_SPACE1_DESC = 14;
    localparam logic [7:0] PLSC_REG_OFFSET [PLSC_NUM_REGS] = '{
        8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
        8'h20, 8'h24, 8'h28, 8'h2c, 8'hf0, 8'hf4, 8'hf8};
    localparam logic [31:0] PLSC_RESET_VALUE [PLSC_NUM_REGS] = '{
        32'hffff_0000, 32'h0000_0001, 32'h11e4_0000, 32'h0000_0000,
        32'hffff_0000, 32'h1000_0010, 32'h4fc3_05c3, 32'hff00_0000,
        32'h4000_0000, 32'h7000_0000, 32'h0000_183f, 32'h0000_0000,
        32'hffc0_0000, 32'h0040_0001, 32'h0000_03c3};
    localparam int PLSC_RANGE_LSB = 4;
    localparam int PLSC_BIT_REMAP_EN = 0;
    localparam int PLSC_BIT_FIFO_SEL = 22;
    localparam int PLSC_BIT_BUSREQ_EN = 4;
    localparam int PLSC_BIT_READY_EN = 6;
    localparam int PLSC_BIT_BURST_TERMINATE_IN_EN = 7;
    localparam int PLSC_BIT_SP0_NOPREF = 8;
    localparam int PLSC_BIT_SP1_NOPREF = 9;
    localparam int PLSC_BIT_SP0_BURST = 24;
    localparam int PLSC_BIT_SP1_BURST = 8;
    localparam int PLSC_BIT_SP1_LOAD = 25;
    localparam int PLSC_BIT_SP0_SWAP = 2;
    localparam int PLSC_BIT_SP1_SWAP = 3;
    localparam int PLSC_BIT_DM_EN = 0;
    localparam logic [31:0] PLSC_ADDR_STEP = 32'h0000_0004;
    localparam logic [3:0] PLSC_LOCAL_WAIT_CYCLES = 4'h2;

    typedef struct packed {
        logic valid;
        logic is_reg;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be;
    } plsc_tgt_req_type;

    typedef struct packed {
        logic done;
        logic hit;
        logic [31:0] data;
    } plsc_tgt_resp_type;

    typedef struct packed {
        logic strobe;
        logic write;
        logic burst;
        logic [31:0] local_address_bus;
        logic [31:0] data;
        logic [3:0] be;
    } plsc_lcl_cyc_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } plsc_mst_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] offset;
        logic [31:0] data;
    } plsc_load_type;

    typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_PREFETCH, ST_MASTER} plsc_state_type;
endpackage
`default_nettype wire

/* File: rtl/plsc_top.sv */
// local configuration and cycle steering of the pci-to-local bridge
// How it works
// - target cycles translate pci address to local address, then prefetch or burst per space
// - target cycles reach internal registers and local spaces zero and one
// - dma requests become pci master transactions in either direction
// - local master cycles inside the direct-master window become pci master cycles
// - range bits 31:4 give window size; space zero at least 16 bytes
// - a space answers only while its remap bit 0 is set
// - local address bit 22 chooses registers or fifo; space one remap sets it
// - endian descriptor zero means no swap; set bits swap bytes per space
// - local bus request output only while expansion-rom remap bit 4 set
// - space zero descriptor: ready bit 6, burst-terminate bit 7, no-prefetch bit 8
// - space one descriptor: ready bit 6, burst-terminate bit 7, no-prefetch bit 9
// - space zero descriptor bit 25 lets loader fill space one registers
// - direct-master pci remap steers direct-master pci addresses
// - all registers can be loaded from serial configuration memory
`timescale 1ns/1ps
`default_nettype none
module plsc_top #(
    parameter logic [3:0] LOCAL_WAIT_CYCLES = plsc_pkg::PLSC_LOCAL_WAIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire plsc_pkg::plsc_tgt_req_type tgt_req_in,
    input wire logic [31:0] space0_pci_base_in,
    input wire logic [31:0] space1_pci_base_in,
    input wire plsc_pkg::plsc_load_type cfg_load_in,
    input wire logic local_ready_in,
    input wire logic burst_terminate_in,
    input wire logic [31:0] local_rdata_in,
    input wire plsc_pkg::plsc_mst_req_type local_master_in,
    input wire plsc_pkg::plsc_mst_req_type dma_req_in,
    input wire logic pci_master_done_in,
    input wire logic [31:0] pci_master_rdata_in,
    output plsc_pkg::plsc_tgt_resp_type tgt_resp_out,
    output plsc_pkg::plsc_lcl_cyc_type local_cyc_out,
    output logic local_bus_request_out,
    output plsc_pkg::plsc_mst_req_type pci_master_out,
    output logic local_master_done_out,
    output logic dma_done_out,
    output logic [31:0] master_rdata_out
);
    import plsc_pkg::*;

    function automatic logic [31:0] plsc_swap(input logic [31:0] d);
        plsc_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    function automatic logic [31:0] plsc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        plsc_merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                plsc_merge[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction

    logic [1:0] ready_sync;
    logic [1:0] burst_terminate_in_sync;
    logic ready_s;
    logic burst_terminate_in_s;
    logic [31:0] regs [PLSC_NUM_REGS];
    logic [PLSC_NUM_REGS-1:0] reg_sel;
    logic [PLSC_NUM_REGS-1:0] load_ok;
    logic [31:0] reg_rdata;
    plsc_state_type state;
    logic armed;
    logic [3:0] wait_cnt;
    logic cur_ready_en, cur_burst_terminate_in_en, cur_pref_en, cur_swap, master_is_dma;
    logic pref_valid;
    logic [31:0] pref_addr, pref_data;

    // ready and burst-terminate pins from the local side pass two flops first; read data does not
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ready_sync <= 2'b00;
            burst_terminate_in_sync <= 2'b00;
        end else begin
            ready_sync <= {ready_sync[0], local_ready_in};
            burst_terminate_in_sync <= {burst_terminate_in_sync[0], burst_terminate_in};
        end
    end
    assign ready_s = ready_sync[1];
    assign burst_terminate_in_s = burst_terminate_in_sync[1];

    logic idle;
    logic tgt_reg_write;
    assign idle = (state == ST_IDLE);
    assign tgt_reg_write = idle && tgt_req_in.valid && tgt_req_in.is_reg && tgt_req_in.write;

    // register file: loader wins over a target write in the same cycle
    for (genvar i = 0; i < PLSC_NUM_REGS; i++) begin : g_reg
        assign reg_sel[i] = ({tgt_req_in.addr[7:2], 2'b00} == PLSC_REG_OFFSET[i]);
        assign load_ok[i] = cfg_load_in.valid && ({cfg_load_in.offset[7:2], 2'b00} ==
            PLSC_REG_OFFSET[i]) && ((i < PLSC_IDX_SPACE1_RANGE) ||
            regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_SP1_LOAD]);
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                regs[i] <= PLSC_RESET_VALUE[i];
            end else if (load_ok[i]) begin
                regs[i] <= cfg_load_in.data;
            end else if (tgt_reg_write && reg_sel[i]) begin
                regs[i] <= plsc_merge(regs[i], tgt_req_in.data, tgt_req_in.be);
            end
        end
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        for (int i = 0; i < PLSC_NUM_REGS; i++) begin
            if (reg_sel[i]) begin
                reg_rdata = regs[i];
            end
        end
    end

    // window decode: range bits below 4 are flags, never address bits
    logic [31:0] mask0, mask1, laddr0, laddr1, sel_laddr;
    logic hit0, hit1, any_hit, pref_hit;
    assign mask0 = {regs[PLSC_IDX_SPACE0_RANGE][31:PLSC_RANGE_LSB], 4'h0};
    assign mask1 = {regs[PLSC_IDX_SPACE1_RANGE][31:PLSC_RANGE_LSB], 4'h0};
    assign hit0 = regs[PLSC_IDX_SPACE0_REMAP][PLSC_BIT_REMAP_EN] &&
        ((tgt_req_in.addr & mask0) == (space0_pci_base_in & mask0));
    assign hit1 = regs[PLSC_IDX_SPACE1_REMAP][PLSC_BIT_REMAP_EN] &&
        ((tgt_req_in.addr & mask1) == (space1_pci_base_in & mask1));
    assign laddr0 = (tgt_req_in.addr & ~mask0) | (regs[PLSC_IDX_SPACE0_REMAP] & mask0);
    // remap bits above the window, bit 22 among them, are forced onto the local bus
    assign laddr1 = (tgt_req_in.addr & ~mask1) | (regs[PLSC_IDX_SPACE1_REMAP] & mask1);
    assign sel_laddr = hit0 ? laddr0 : laddr1;
    assign any_hit = hit0 || hit1;
    assign pref_hit = pref_valid && !tgt_req_in.write && any_hit && (sel_laddr == pref_addr);

    logic sel_ready_en, sel_burst_terminate_in_en, sel_pref_en, sel_burst_en, sel_swap;
    always_comb begin
        if (hit0) begin
            sel_ready_en = regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_READY_EN];
            sel_burst_terminate_in_en = regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_BURST_TERMINATE_IN_EN];
            sel_pref_en = !regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_SP0_NOPREF];
            sel_burst_en = regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_SP0_BURST];
            sel_swap = regs[PLSC_IDX_ENDIAN][PLSC_BIT_SP0_SWAP];
        end else begin
            sel_ready_en = regs[PLSC_IDX_SPACE1_DESC][PLSC_BIT_READY_EN];
            sel_burst_terminate_in_en = regs[PLSC_IDX_SPACE1_DESC][PLSC_BIT_BURST_TERMINATE_IN_EN];
            sel_pref_en = !regs[PLSC_IDX_SPACE1_DESC][PLSC_BIT_SP1_NOPREF];
            sel_burst_en = regs[PLSC_IDX_SPACE1_DESC][PLSC_BIT_SP1_BURST];
            sel_swap = regs[PLSC_IDX_ENDIAN][PLSC_BIT_SP1_SWAP];
        end
    end

    // direct-master window
    logic [31:0] dm_mask, lm_pci_addr;
    logic lm_hit;
    assign dm_mask = regs[PLSC_IDX_DM_RANGE];
    assign lm_hit = regs[PLSC_IDX_DM_PCI_REMAP][PLSC_BIT_DM_EN] &&
        ((local_master_in.addr & dm_mask) == (regs[PLSC_IDX_DM_MEM_BASE] & dm_mask));
    assign lm_pci_addr = (local_master_in.addr & ~dm_mask) |
        (regs[PLSC_IDX_DM_PCI_REMAP] & dm_mask);

    // arbitration in idle: target, then dma, then local master
    logic tgt_go, start_local, start_dma, lm_go, start_lm;
    assign tgt_go = idle && tgt_req_in.valid;
    assign start_local = tgt_go && !tgt_req_in.is_reg && any_hit && !pref_hit;
    assign start_dma = idle && !tgt_req_in.valid && dma_req_in.valid;
    assign lm_go = idle && !tgt_req_in.valid && !dma_req_in.valid && local_master_in.valid;
    assign start_lm = lm_go && lm_hit;

    logic lcl_active, burst_terminate_in_end, lcl_complete, go_prefetch;
    assign lcl_active = (state == ST_LOCAL) || (state == ST_PREFETCH);
    assign burst_terminate_in_end = cur_burst_terminate_in_en && burst_terminate_in_s;
    assign lcl_complete = lcl_active && armed &&
        ((cur_ready_en ? ready_s : (wait_cnt == 4'h0)) || burst_terminate_in_end);
    assign go_prefetch = (state == ST_LOCAL) && lcl_complete && !local_cyc_out.write &&
        cur_pref_en && !burst_terminate_in_end;

    // cycle sequencer and local bus strobes
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            local_cyc_out <= '0;
            armed <= 1'b0;
            wait_cnt <= 4'h0;
            cur_ready_en <= 1'b0;
            cur_burst_terminate_in_en <= 1'b0;
            cur_pref_en <= 1'b0;
            cur_swap <= 1'b0;
            master_is_dma <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_local) begin
                        state <= ST_LOCAL;
                        armed <= 1'b0;
                        cur_ready_en <= sel_ready_en;
                        cur_burst_terminate_in_en <= sel_burst_terminate_in_en;
                        cur_pref_en <= sel_pref_en;
                        cur_swap <= sel_swap;
                        local_cyc_out.write <= tgt_req_in.write;
                        local_cyc_out.burst <= sel_burst_en && sel_pref_en && !tgt_req_in.write;
                        local_cyc_out.local_address_bus <= sel_laddr;
                        local_cyc_out.data <= sel_swap ? plsc_swap(tgt_req_in.data)
                                                       : tgt_req_in.data;
                        local_cyc_out.be <= sel_swap ? {tgt_req_in.be[0], tgt_req_in.be[1], tgt_req_in.be[2], tgt_req_in.be[3]} : tgt_req_in.be;
                    end else if (start_dma) begin
                        state <= ST_MASTER;
                        master_is_dma <= 1'b1;
                    end else if (start_lm) begin
                        state <= ST_MASTER;
                        master_is_dma <= 1'b0;
                    end
                end
                ST_LOCAL, ST_PREFETCH: begin
                    if (!armed) begin
                        // wait for the previous ready to fall before a new strobe
                        if (!ready_s) begin
                            armed <= 1'b1;
                            local_cyc_out.strobe <= 1'b1;
                            wait_cnt <= LOCAL_WAIT_CYCLES - 4'h1;
                        end
                    end else if (lcl_complete) begin
                        armed <= 1'b0;
                        local_cyc_out.strobe <= 1'b0;
                        if (go_prefetch) begin
                            state <= ST_PREFETCH;
                            local_cyc_out.local_address_bus <=
                                local_cyc_out.local_address_bus + PLSC_ADDR_STEP;
                        end else begin
                            state <= ST_IDLE;
                            local_cyc_out.burst <= 1'b0;
                        end
                    end else if (wait_cnt != 4'h0) begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                ST_MASTER: begin
                    if (pci_master_done_in) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // one-word prefetch buffer, dropped on any write or on a terminated burst
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pref_valid <= 1'b0;
            pref_addr <= 32'h0000_0000;
            pref_data <= 32'h0000_0000;
        end else if (go_prefetch) begin
            pref_valid <= 1'b0;
            pref_addr <= local_cyc_out.local_address_bus + PLSC_ADDR_STEP;
        end else if (state == ST_PREFETCH && lcl_complete) begin
            pref_valid <= !burst_terminate_in_end;
            pref_data <= cur_swap ? plsc_swap(local_rdata_in) : local_rdata_in;
        end else if ((tgt_go && (tgt_req_in.write || pref_hit)) || cfg_load_in.valid) begin
            pref_valid <= 1'b0;
        end
    end

    // target answers
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tgt_resp_out <= '0;
        end else begin
            tgt_resp_out.done <= 1'b0;
            if (tgt_go && tgt_req_in.is_reg) begin
                tgt_resp_out.done <= 1'b1;
                tgt_resp_out.hit <= |reg_sel;
                tgt_resp_out.data <= tgt_req_in.write ? 32'h0000_0000 : reg_rdata;
            end else if (tgt_go && !any_hit) begin
                tgt_resp_out.done <= 1'b1;
                tgt_resp_out.hit <= 1'b0;
                tgt_resp_out.data <= 32'h0000_0000;
            end else if (tgt_go && pref_hit) begin
                tgt_resp_out.done <= 1'b1;
                tgt_resp_out.hit <= 1'b1;
                tgt_resp_out.data <= pref_data;
            end else if (state == ST_LOCAL && lcl_complete) begin
                tgt_resp_out.done <= 1'b1;
                tgt_resp_out.hit <= 1'b1;
                tgt_resp_out.data <= local_cyc_out.write ? 32'h0000_0000 :
                    (cur_swap ? plsc_swap(local_rdata_in) : local_rdata_in);
            end
        end
    end

    // pci master side
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pci_master_out <= '0;
            local_master_done_out <= 1'b0;
            dma_done_out <= 1'b0;
            master_rdata_out <= 32'h0000_0000;
            local_bus_request_out <= 1'b0;
        end else begin
            local_master_done_out <= 1'b0;
            dma_done_out <= 1'b0;
            local_bus_request_out <= regs[PLSC_IDX_EXPROM_REMAP][PLSC_BIT_BUSREQ_EN] &&
                (start_dma || start_lm ||
                 (state == ST_MASTER && !pci_master_done_in));
            if (start_dma) begin
                pci_master_out <= '{valid: 1'b1, write: dma_req_in.write,
                    addr: dma_req_in.addr, data: dma_req_in.data};
            end else if (start_lm) begin
                pci_master_out <= '{valid: 1'b1, write: local_master_in.write,
                    addr: lm_pci_addr, data: local_master_in.data};
            end else if (lm_go) begin
                local_master_done_out <= 1'b1;
                master_rdata_out <= 32'h0000_0000;
            end else if (state == ST_MASTER && pci_master_done_in) begin
                pci_master_out.valid <= 1'b0;
                master_rdata_out <= pci_master_rdata_in;
                dma_done_out <= master_is_dma;
                local_master_done_out <= !master_is_dma;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_reg_answer: assert property ((tgt_go && tgt_req_in.is_reg) |=>
        tgt_resp_out.done && (tgt_resp_out.hit == $past(|reg_sel)))
        else $error("register access not answered next cycle");
    a_space_disabled: assert property ((tgt_go && !tgt_req_in.is_reg &&
        !regs[PLSC_IDX_SPACE0_REMAP][0] && !regs[PLSC_IDX_SPACE1_REMAP][0]) |=>
        tgt_resp_out.done && !tgt_resp_out.hit && state == ST_IDLE)
        else $error("disabled space answered a cycle");
    a_space0_map: assert property ((start_local && hit0) |=>
        state == ST_LOCAL && local_cyc_out.local_address_bus == $past(laddr0))
        else $error("space zero address not remapped");
    a_fifo_select: assert property ((start_local && !hit0 && mask1[22] &&
        regs[PLSC_IDX_SPACE1_REMAP][22]) |=> local_cyc_out.local_address_bus[22])
        else $error("space one cycle missed the fifo select bit");
    a_ready_wait: assert property ((local_cyc_out.strobe && cur_ready_en && !ready_s &&
        !burst_terminate_in_end) |=> local_cyc_out.strobe && !tgt_resp_out.done)
        else $error("local cycle ended without ready");
    a_no_prefetch: assert property ((state == ST_LOCAL && lcl_complete &&
        !local_cyc_out.write && !cur_pref_en) |=> state == ST_IDLE ##1 !local_cyc_out.strobe)
        else $error("prefetch ran with prefetch disabled");
    a_busreq_gate: assert property (local_bus_request_out |->
        $past(regs[PLSC_IDX_EXPROM_REMAP][PLSC_BIT_BUSREQ_EN]) && state == ST_MASTER)
        else $error("bus request without enable bit");
    a_dma_master: assert property (start_dma |=> pci_master_out.valid &&
        pci_master_out.addr == $past(dma_req_in.addr) && state == ST_MASTER)
        else $error("dma request did not start a pci cycle");
    a_dm_remap: assert property (start_lm |=> pci_master_out.valid &&
        pci_master_out.addr == $past(lm_pci_addr))
        else $error("direct master address not remapped");
    a_sp1_load_gate: assert property ((cfg_load_in.valid &&
        cfg_load_in.offset == PLSC_REG_OFFSET[PLSC_IDX_SPACE1_RANGE] &&
        !regs[PLSC_IDX_SPACE0_DESC][PLSC_BIT_SP1_LOAD] && !tgt_reg_write) |=>
        $stable(regs[PLSC_IDX_SPACE1_RANGE]))
        else $error("space one loaded without enable bit");

    c_reg_read: cover property (tgt_go && tgt_req_in.is_reg && !tgt_req_in.write);
    c_space1_write: cover property (start_local && !hit0 && tgt_req_in.write);
    c_prefetch_hit: cover property (tgt_go && pref_hit);
    c_master_done: cover property (state == ST_MASTER && pci_master_done_in);
endmodule // plsc_top
`default_nettype wire

/* File: verification/plsc_local_partner.sv */
// local-bus logic model: answers beats with ready and address-derived data
`timescale 1ns/1ps
`default_nettype none
module plsc_local_partner (
    input wire logic clk_in,
    input wire plsc_pkg::plsc_lcl_cyc_type local_cyc_in,
    input wire logic [3:0] delay_in,
    output logic ready_out,
    output logic terminate_out,
    output logic [31:0] rdata_out
);
    import plsc_pkg::*;
    logic [3:0] wait_count;
    initial begin
        ready_out = 1'b0;
        terminate_out = 1'b0;
        rdata_out = 32'h0000_0000;
        wait_count = 4'h0;
    end
    always @(posedge clk_in) begin
        if (!local_cyc_in.strobe) begin
            ready_out <= 1'b0;
            wait_count <= 4'h0;
            rdata_out <= ~rdata_out; // released bus keeps toggling
        end else if (wait_count >= delay_in) begin
            ready_out <= 1'b1;
            rdata_out <= ~local_cyc_in.local_address_bus;
        end else begin
            wait_count <= wait_count + 4'h1;
        end
    end
endmodule // plsc_local_partner
`default_nettype wire

/* File: verification/test_plsc_top.sv */
// self-checking bench for the local configuration block
`timescale 1ns/1ps
`default_nettype none
module test_plsc_top;
    import plsc_pkg::*;
    logic clk_in = 0, reset_in = 1, ready, term, dma_done, lm_done, breq, pm_done = 0;
    logic [31:0] rdata, m_rdata, rnd;
    logic [3:0] dly = 4'h1;
    plsc_tgt_req_type req = '0;
    plsc_tgt_resp_type resp;
    plsc_lcl_cyc_type cyc;
    plsc_mst_req_type dma = '0, lm = '0, pm;
    plsc_load_type ld = '0;
    logic [32:0] exp_q[$];
    int n_fail = 0, tests_run = 0, cycles = 0;
    always #2.5 clk_in = ~clk_in;
    plsc_top u_plsc_top (.clk_in(clk_in), .reset_in(reset_in), .tgt_req_in(req),
        .space0_pci_base_in(32'h4000_0000), .space1_pci_base_in(32'h8000_0000),
        .cfg_load_in(ld), .local_ready_in(ready), .burst_terminate_in(term),
        .local_rdata_in(rdata), .local_master_in(lm), .dma_req_in(dma),
        .pci_master_done_in(pm_done), .pci_master_rdata_in(32'h1234_5678),
        .tgt_resp_out(resp), .local_cyc_out(cyc), .local_bus_request_out(breq),
        .pci_master_out(pm), .local_master_done_out(lm_done), .dma_done_out(dma_done),
        .master_rdata_out(m_rdata));
    plsc_local_partner u_plsc_local_partner (.clk_in(clk_in), .local_cyc_in(cyc),
        .delay_in(dly), .ready_out(ready), .terminate_out(term), .rdata_out(rdata));
    task automatic final_report();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string name, logic [32:0] seen, logic [32:0] expv);
        tests_run++;
        if (seen !== expv) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, expv, seen);
        end
    endtask
    task automatic access(logic is_reg, logic wr, logic [31:0] a, logic [31:0] d,
        logic [32:0] expv);
        int k;
        @(negedge clk_in);
        req <= '{1'b1, is_reg, wr, a, d, 4'hf};
        exp_q.push_back(expv);
        @(negedge clk_in);
        req <= '0;
        for (k = 0; k < 50 && exp_q.size() != 0; k++) @(negedge clk_in);
        if (exp_q.size() != 0) begin
            chk("answer timeout", 33'h1, 33'h0);
            exp_q.delete();
        end
    endtask
    task automatic load(logic [7:0] o, logic [31:0] d);
        @(negedge clk_in);
        ld <= '{1'b1, o, d};
        @(negedge clk_in);
        ld <= '0;
    endtask
    task automatic dma_run(logic exp_req, logic use_lm, logic [31:0] a, logic [31:0] exp_a);
        int k;
        @(negedge clk_in);
        if (use_lm) lm <= '{1'b1, 1'b0, a, 32'h0000_0000};
        else dma <= '{1'b1, 1'b0, a, 32'h0000_0000};
        @(negedge clk_in);
        lm <= '0;
        dma <= '0;
        for (k = 0; k < 20 && pm.valid !== 1'b1; k++) @(negedge clk_in);
        @(negedge clk_in);
        chk("bus request", {32'h0, breq}, {32'h0, exp_req});
        chk("pci address", {1'b0, pm.addr}, {1'b0, exp_a});
        pm_done <= 1'b1;
        @(negedge clk_in);
        pm_done <= 1'b0;
        chk("dma done", {32'h0, dma_done}, {32'h0, !use_lm});
        chk("local master done", {32'h0, lm_done}, {32'h0, use_lm});
        chk("master data", {1'b0, m_rdata}, {1'b0, 32'h1234_5678});
    endtask
    always @(negedge clk_in) begin
        if (resp.done === 1'b1) begin
            if (exp_q.size() == 0) chk("stray answer", 33'h1, 33'h0);
            else chk("target answer", {resp.hit, resp.data}, exp_q.pop_front());
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        int i;
        rnd = $urandom(32'h45d57fb9);
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        for (i = 0; i < PLSC_NUM_REGS; i++) begin
            access(1, 0, {24'h0, PLSC_REG_OFFSET[i]}, 0, {1'b1, PLSC_RESET_VALUE[i]});
        end
        rnd = $urandom();
        access(1, 1, 32'h0000_000c, rnd, {1'b1, 32'h0});
        access(1, 0, 32'h0000_000c, 0, {1'b1, rnd});
        access(1, 1, 32'h0000_000c, 32'h0000_0008, {1'b1, 32'h0});
        access(0, 0, 32'h8000_0010, 0, {1'b1, 32'hefff_bfff});
        access(1, 1, 32'h0000_000c, 0, {1'b1, 32'h0});
        access(1, 0, 32'h0000_0030, 0, 33'h0);
        access(1, 1, 32'h0000_0008, rnd | 32'h0024_0000, {1'b1, 32'h0});
        access(1, 0, 32'h0000_0008, 0, {1'b1, rnd | 32'h0024_0000});
        access(1, 1, 32'h0000_00f0, 32'hffe0_0000, {1'b1, 32'h0});
        access(0, 0, 32'h801f_fff0, 0, {1'b1, ~32'h005f_fff0});
        access(1, 1, 32'h0000_00f0, 32'hffc0_0000, {1'b1, 32'h0});
        load(8'h2c, rnd);
        access(1, 0, 32'h0000_002c, 0, {1'b1, rnd});
        access(1, 1, 32'h0000_0018, 32'h4dc3_05c3, {1'b1, 32'h0});
        load(8'hf0, rnd);
        access(1, 0, 32'h0000_00f0, 0, {1'b1, 32'hffc0_0000});
        for (i = 0; i < 3; i++) begin
            dly = 4'($urandom() % 4);
            access(0, 0, 32'h8000_0010, 0, {1'b1, ~32'h0040_0010});
            access(0, 0, 32'h4000_0024, 0, {1'b1, ~32'h0000_0024});
        end
        access(1, 1, 32'h0000_0004, 0, {1'b1, 32'h0});
        access(0, 0, 32'h4000_0024, 0, 33'h0);
        access(1, 1, 32'h0000_00f4, 0, {1'b1, 32'h0});
        access(0, 0, 32'h8000_0010, 0, 33'h0);
        dma_run(1'b1, 1'b0, 32'h00bc_0010, 32'h00bc_0010);
        access(1, 1, 32'h0000_0014, 32'h1000_0000, {1'b1, 32'h0});
        dma_run(1'b0, 1'b0, 32'h00bc_0010, 32'h00bc_0010);
        dma_run(1'b0, 1'b1, 32'h4012_3450, 32'h0012_3450);
        final_report();
    end
endmodule // test_plsc_top
`default_nettype wire
